// ===== rtl/irm_slave.sv
// I2C slave with row-organised EEPROM write commit and table read wrap
`timescale 1ns/1ns
`include "irm_defs.svh"

// Functional notes
// [RQ1] Master writes start, address, memaddr, data, stop
// [RQ2] Master writes at most four data bytes
// [RQ3] Accept one to four bytes, counter advances
// [RQ4] Write counter wraps inside its row
// [RQ5] Master stops and waits before next row
// [RQ6] Address not acknowledged during commit time
// [RQ7] Master polls address or waits full time
// [RQ8] Commit writes whole row, keeps old bytes
// [RQ9] Read returns byte at current counter
// [RQ10] Dummy write loads counter for reads
// [RQ11] Read counter advances per byte; ACK continues
// [RQ12] Read counter wraps within memory table
// [RQ13] Bytes MSB first; first byte is address
// [RQ14] Respond only to address 1010000, lsb direction
// [RQ15] Chip select low needed to respond
// [RQ16] Wrong address ignored until next start
// [RQ17] Second byte of write loads counter
// [RQ18] Busy from stop for commit duration

module irm_slave #(
  parameter int unsigned COMMIT_TIME_NS = `IRM_COMMIT_TIME_NS
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // I2C bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // Chip select pin
  input  wire logic bus_chip_select_n,
  // Status
  output logic      commit_busy
);

  // ****************************************************************
  // Constants and helpers
  // ****************************************************************
  localparam int unsigned COMMIT_CYCLES_RAW =
    (COMMIT_TIME_NS + `IRM_CLK_PERIOD_NS - 1) / `IRM_CLK_PERIOD_NS;
  localparam int unsigned COMMIT_CYCLES =
    (COMMIT_CYCLES_RAW < 1) ? 1 : COMMIT_CYCLES_RAW;
  localparam logic [31:0] COMMIT_LAST = 32'(COMMIT_CYCLES - 1);

  // Next read address: wraps to the first byte of the same table
  function automatic logic [7:0] rd_next(input logic [7:0] a);
    rd_next = {a[`IRM_TABLE_BIT], a[6:0] + 7'h01};  // [RQ12]
  endfunction

  // Next write address: wraps to the first byte of the same row
  function automatic logic [7:0] wr_next(input logic [7:0] a);
    wr_next = {a[7:`IRM_ROW_LSB], a[1:0] + 2'h1};  // [RQ4]
  endfunction

  // ****************************************************************
  // Pin synchronisers and bus conditions
  // ****************************************************************
  irm_pkg::irm_pins_type meta_ff;
  irm_pkg::irm_pins_type sync_ff;
  irm_pkg::irm_pins_type prev_ff;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '{scl: 1'b1, sda: 1'b1, csn: 1'b1};
      sync_ff <= '{scl: 1'b1, sda: 1'b1, csn: 1'b1};
      prev_ff <= '{scl: 1'b1, sda: 1'b1, csn: 1'b1};
    end else begin
      meta_ff <= '{scl: scl_i, sda: sda_i, csn: bus_chip_select_n};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = sync_ff.scl & ~prev_ff.scl;
  assign scl_fall  = ~sync_ff.scl & prev_ff.scl;
  // SDA moving while SCL stays high marks start and stop
  assign bus_start = sync_ff.scl & prev_ff.scl & prev_ff.sda & ~sync_ff.sda;
  assign bus_stop  = sync_ff.scl & prev_ff.scl & ~prev_ff.sda & sync_ff.sda;

  // ****************************************************************
  // Memory, row buffer and address counter
  // ****************************************************************
  logic [7:0]               mem_ff [256];
  logic [7:0]               row_ff [`IRM_ROW_BYTES];
  logic [7:0]               cnt_ff;
  logic [5:0]               row_base_ff;
  logic                     dirty_ff;
  logic [31:0]              commit_cnt_ff;
  logic                     commit_busy_ff;

  irm_pkg::irm_state_type   state_ff;
  irm_pkg::irm_byte_type    byte_ff;
  logic [3:0]               bit_ff;
  logic [7:0]               shift_ff;
  logic                     rw_ff;
  logic                     more_ff;
  logic                     sda_oe_ff;
  logic                     sda_o_ff;

  logic                     byte_done;
  logic                     addr_ok;

  assign byte_done = (state_ff == irm_pkg::ST_RX) && scl_fall &&
                     (bit_ff == `IRM_BYTE_BITS);
  // Address match, chip selected and not committing
  assign addr_ok   = (shift_ff[7:1] == `IRM_SLAVE_ADDR) &&   // [RQ14]
                     !sync_ff.csn &&                          // [RQ15]
                     !commit_busy_ff;                         // [RQ6]

  // ****************************************************************
  // Byte engine
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff  <= irm_pkg::ST_IDLE;
      byte_ff   <= irm_pkg::BY_SLAVE;
      bit_ff    <= 4'h0;
      shift_ff  <= 8'h00;
      rw_ff     <= 1'b0;
      more_ff   <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (bus_start) begin
      // First byte after any start is the address byte
      state_ff  <= irm_pkg::ST_RX;                           // [RQ13]
      byte_ff   <= irm_pkg::BY_SLAVE;
      bit_ff    <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (bus_stop) begin
      state_ff  <= irm_pkg::ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        irm_pkg::ST_IDLE: begin
          sda_oe_ff <= 1'b0;                                  // [RQ16]
        end
        irm_pkg::ST_RX: begin
          if (scl_rise && bit_ff != `IRM_BYTE_BITS) begin
            shift_ff <= {shift_ff[6:0], sync_ff.sda};         // [RQ13]
            bit_ff   <= bit_ff + 4'h1;
          end else if (byte_done) begin
            if (byte_ff == irm_pkg::BY_SLAVE && !addr_ok) begin
              state_ff <= irm_pkg::ST_IDLE;                   // [RQ16]
            end else begin
              sda_oe_ff <= 1'b1;
              state_ff  <= irm_pkg::ST_ACK;
              if (byte_ff == irm_pkg::BY_SLAVE) begin
                rw_ff   <= shift_ff[0];                       // [RQ14]
                byte_ff <= irm_pkg::BY_MEMADDR;
              end else begin
                byte_ff <= irm_pkg::BY_DATA;
              end
            end
          end
        end
        irm_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              // Read: present the MSB right after the ACK clock
              shift_ff  <= {mem_ff[cnt_ff][6:0], 1'b0};       // [RQ9]
              sda_oe_ff <= ~mem_ff[cnt_ff][7];
              bit_ff    <= 4'h1;
              state_ff  <= irm_pkg::ST_TX;
            end else begin
              sda_oe_ff <= 1'b0;
              bit_ff    <= 4'h0;
              state_ff  <= irm_pkg::ST_RX;
            end
          end
        end
        irm_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_ff == `IRM_BYTE_BITS) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= irm_pkg::ST_MACK;
            end else begin
              sda_oe_ff <= ~shift_ff[7];
              shift_ff  <= {shift_ff[6:0], 1'b0};
              bit_ff    <= bit_ff + 4'h1;
            end
          end
        end
        irm_pkg::ST_MACK: begin
          if (scl_rise) begin
            more_ff <= ~sync_ff.sda;                          // [RQ11]
          end else if (scl_fall) begin
            if (more_ff) begin
              shift_ff  <= {mem_ff[cnt_ff][6:0], 1'b0};       // [RQ11]
              sda_oe_ff <= ~mem_ff[cnt_ff][7];
              bit_ff    <= 4'h1;
              state_ff  <= irm_pkg::ST_TX;
            end else begin
              state_ff  <= irm_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Address counter and row buffer
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff      <= `IRM_CNT_RESET;
      row_base_ff <= 6'h00;
      dirty_ff    <= 1'b0;
      for (int i = 0; i < `IRM_ROW_BYTES; i++) begin
        row_ff[i] <= 8'h00;
      end
    end else if (bus_stop && dirty_ff) begin
      dirty_ff <= 1'b0;                                       // [RQ18]
    end else if (byte_done && !rw_ff &&
                 byte_ff == irm_pkg::BY_MEMADDR) begin
      cnt_ff      <= shift_ff;                                // [RQ17]
      row_base_ff <= shift_ff[7:`IRM_ROW_LSB];                // [RQ10]
      // Preload so untouched bytes keep their old contents
      for (int i = 0; i < `IRM_ROW_BYTES; i++) begin
        row_ff[i] <= mem_ff[{shift_ff[7:2], 2'(i)}];          // [RQ8]
      end
    end else if (byte_done && !rw_ff &&
                 byte_ff == irm_pkg::BY_DATA) begin
      row_ff[cnt_ff[1:0]] <= shift_ff;                        // [RQ3]
      cnt_ff              <= wr_next(cnt_ff);                 // [RQ4]
      dirty_ff            <= 1'b1;
    end else if (state_ff == irm_pkg::ST_TX && scl_fall &&
                 bit_ff == `IRM_BYTE_BITS) begin
      cnt_ff <= rd_next(cnt_ff);                              // [RQ11]
    end
  end

  // ****************************************************************
  // EEPROM commit
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      commit_busy_ff <= 1'b0;
      commit_cnt_ff  <= 32'h0000_0000;
    end else if (bus_stop && dirty_ff) begin
      commit_busy_ff <= 1'b1;                                 // [RQ18]
      commit_cnt_ff  <= 32'h0000_0000;
    end else if (commit_busy_ff) begin
      if (commit_cnt_ff == COMMIT_LAST) begin
        commit_busy_ff <= 1'b0;                               // [RQ6]
      end else begin
        commit_cnt_ff <= commit_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // Whole row written at once at the end of the commit time;
  // an array without reset keeps the store small
  always_ff @(posedge mclk) begin
    if (commit_busy_ff && commit_cnt_ff == COMMIT_LAST) begin
      for (int i = 0; i < `IRM_ROW_BYTES; i++) begin
        mem_ff[{row_base_ff, 2'(i)}] <= row_ff[i];            // [RQ8]
      end
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sda_o_ff <= 1'b0;
    end else begin
      sda_o_ff <= 1'b0;
    end
  end

  assign sda_o       = sda_o_ff;
  assign sda_oe      = sda_oe_ff;
  assign commit_busy = commit_busy_ff;

endmodule

// ===== rtl/irm_defs.svh
// Constants for the row memory I2C slave
`ifndef IRM_DEFS_SVH
`define IRM_DEFS_SVH

// Own slave address, upper seven bits of the address byte
`define IRM_SLAVE_ADDR     7'h50
// Clock period of mclk in ns
`define IRM_CLK_PERIOD_NS  4
// Default EEPROM commit time in ns
`define IRM_COMMIT_TIME_NS 5000000
// Bits per byte on the bus
`define IRM_BYTE_BITS      4'h8
// Field positions of a memory address
`define IRM_TABLE_BIT      7
`define IRM_ROW_LSB        2
// Bytes per row
`define IRM_ROW_BYTES      4
// Reset value of the address counter
`define IRM_CNT_RESET      8'h00

`endif

// ===== rtl/irm_pkg.sv
// Types for the row memory I2C slave
package irm_pkg;

  typedef struct packed {
    logic scl;
    logic sda;
    logic csn;
  } irm_pins_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } irm_state_type;

  typedef enum logic [1:0] {
    BY_SLAVE,
    BY_MEMADDR,
    BY_DATA
  } irm_byte_type;

endpackage

// ===== sim/irm_monitor.sv
// Pin-level checker for the row memory I2C slave
`timescale 1ns/1ns
module irm_monitor #(
  parameter int unsigned COMMIT_TIME_NS = 400
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Bus pins and status
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic bus_chip_select_n,
  input wire logic commit_busy
);
  // ********
  // Helpers
  // ********
  localparam int unsigned BUSY_CYC = (COMMIT_TIME_NS + 3) / 4;
  logic [15:0] busy_cnt_ff;
  logic [7:0]  idle_cnt_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      busy_cnt_ff <= 16'h0;
    else
      busy_cnt_ff <= commit_busy ? busy_cnt_ff + 16'h1 : 16'h0;
  end
  // Saturates so a long idle bus cannot wrap back into a frame count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      idle_cnt_ff <= 8'h0;
    else if (!scl_i)
      idle_cnt_ff <= 8'h0;
    else if (idle_cnt_ff != 8'hff)
      idle_cnt_ff <= idle_cnt_ff + 8'h1;
  end
  drive_zero_a: assert property (sda_o == 1'b0)
    else $error("sda_o driven high");
  busy_noack_a: assert property (commit_busy |-> !sda_oe)
    else $error("acknowledge during commit");
  oe_edge_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda changed while scl high");
  oe_hold_a: assert property ($rose(scl_i) && sda_oe |=> sda_oe[*8])
    else $error("sda drive dropped in scl high");
  busy_len_a: assert property ($fell(commit_busy) |->
    busy_cnt_ff == BUSY_CYC) else $error("commit length wrong");
  busy_stop_a: assert property ($rose(commit_busy) |-> scl_i && sda_i)
    else $error("commit began outside stop");
  busy_min_a: assert property ($rose(commit_busy) |=> commit_busy[*8])
    else $error("commit too short");
  idle_free_a: assert property (idle_cnt_ff > 8'h28 |-> !sda_oe)
    else $error("sda held on idle bus");
endmodule
bind irm_slave irm_monitor #(.COMMIT_TIME_NS(COMMIT_TIME_NS)) i_irm_monitor (
  .mclk(mclk), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .bus_chip_select_n(bus_chip_select_n),
  .commit_busy(commit_busy));

// ===== sim/irm_master.sv
// Behavioural I2C bus master facing the slave
`timescale 1ns/1ns
module irm_master (
  // Bus pins
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  // SCL stands high between frames; SDA released reads as pulled up
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // One 125 ns bit; SDA moves only while SCL is low
  task automatic bit_io(input logic b, output logic q);
    sda_m = b;
    #31 scl = 1'b1;
    #31 q = sda;
    #32 scl = 1'b0;
    #31;
  endtask
  task automatic start();
    sda_m = 1'b1;
    #31 scl = 1'b1;
    #31 sda_m = 1'b0;
    #31 scl = 1'b0;
    #32;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #31 scl = 1'b1;
    #31 sda_m = 1'b1;
    #63;
  endtask
  // Acknowledge is read after every written byte; rd_byte drives it instead
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q);
    bit_io(1'b1, q);
    ack = !q;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic q;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, q);
  endtask
endmodule

// ===== sim/irm_slave_tb.sv
// Self-checking bench for the row memory I2C slave
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module irm_slave_tb;
  logic       mclk, arst_n, scl, sda_m, sda_o, sda_oe;
  logic       bus_chip_select_n, commit_busy, ack;
  logic [7:0] d, cnt;
  logic [7:0] mem [256];
  int         n_fail, n_tests;
  wire logic  sda = sda_m & ~sda_oe;
  irm_slave #(.COMMIT_TIME_NS(4000)) i_irm_slave (.mclk(mclk),
    .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .bus_chip_select_n(bus_chip_select_n),
    .commit_busy(commit_busy));
  irm_master i_irm_master (.scl(scl), .sda_m(sda_m), .sda(sda));
  task automatic end_sim();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Write a row, then poll the address until the commit is over
  task automatic wr(input logic [7:0] ma, input logic [31:0] q,
                    input int n);
    int polls;
    i_irm_master.start();
    i_irm_master.wr_byte(8'ha0, ack);
    `CHK("addr ack", 1'b1, ack)
    i_irm_master.wr_byte(ma, ack);
    `CHK("memaddr ack", 1'b1, ack)
    cnt = ma;
    for (int i = 0; i < n; i++) begin
      i_irm_master.wr_byte(q[31-8*i -: 8], ack);
      `CHK("data ack", 1'b1, ack)
      mem[cnt] = q[31-8*i -: 8];
      cnt = {cnt[7:2], cnt[1:0] + 2'h1};
    end
    i_irm_master.stop();
    @(negedge mclk);
    `CHK("busy set", 1'b1, commit_busy)
    polls = 0;
    ack = 1'b0;
    while (!ack && polls < 10) begin
      i_irm_master.start();
      i_irm_master.wr_byte(8'ha0, ack);
      i_irm_master.stop();
      polls++;
    end
    `CHK("busy nack", 1'b1, polls > 1)
    `CHK("poll ack", 1'b1, ack)
    `CHK("busy clear", 1'b0, commit_busy)
  endtask
  task automatic rd(input logic dummy, input logic [7:0] ma, input int n);
    if (dummy) begin
      i_irm_master.start();
      i_irm_master.wr_byte(8'ha0, ack);
      i_irm_master.wr_byte(ma, ack);
      cnt = ma;
    end
    i_irm_master.start();
    i_irm_master.wr_byte(8'ha1, ack);
    `CHK("read addr ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      i_irm_master.rd_byte(i < n - 1, d);
      `CHK("read data", mem[cnt], d)
      cnt = {cnt[7], cnt[6:0] + 7'h1};
    end
    i_irm_master.stop();
  endtask
  task automatic refuse();
    @(negedge mclk) bus_chip_select_n = 1'b1;
    i_irm_master.start();
    i_irm_master.wr_byte(8'ha1, ack);
    `CHK("deselected", 1'b0, ack)
    i_irm_master.stop();
    @(negedge mclk) bus_chip_select_n = 1'b0;
    i_irm_master.start();
    i_irm_master.wr_byte(8'ha2, ack);
    `CHK("other addr", 1'b0, ack)
    i_irm_master.wr_byte(8'ha0, ack);
    `CHK("ignored byte", 1'b0, ack)
    i_irm_master.stop();
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Long enough for every transfer with generous slack
  initial begin
    #250000;
    n_fail++;
    end_sim();
  end
  initial begin
    arst_n = 1'b0;
    bus_chip_select_n = 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk) arst_n = 1'b1;
    repeat (8) @(negedge mclk);
    wr(8'h05, 32'h1122_3344, 4);
    rd(1'b1, 8'h04, 4);
    wr(8'h06, 32'haa00_0000, 1);
    rd(1'b1, 8'h04, 4);
    wr(8'h7c, 32'h0102_0304, 4);
    wr(8'h00, 32'h0506_0708, 4);
    wr(8'hfc, 32'h090a_0b0c, 4);
    wr(8'h80, 32'h0d0e_0f10, 4);
    rd(1'b1, 8'h7e, 4);
    rd(1'b1, 8'hfd, 4);
    rd(1'b0, 8'h00, 2);
    refuse();
    rd(1'b0, 8'h00, 1);
    end_sim();
  end
endmodule
